//--- pkg/wcb_pkg.sv
package wcb_pkg;
  localparam int ADDR_W = 32;
  localparam int CHUNK_BYTES = 8;
  localparam int CHUNK_W = CHUNK_BYTES * 8;
  localparam int CHUNK_OFF_W = 3;
  localparam int LINE_BYTES_WIDE = 64;
  localparam int LINE_BYTES_NARROW = 32;
  localparam int NUM_LINES_DEF = 4;
  localparam int FIFO_DEPTH_DEF = 4;
  localparam logic [CHUNK_OFF_W-1:0] CHUNK_OFF_ZERO = 3'h0;
  localparam logic [CHUNK_BYTES-1:0] BE_NONE = 8'h00;
  // Bus word: burst flag, last flag, byte address, byte mask, data
  localparam int BUS_W = 2 + ADDR_W + CHUNK_BYTES + CHUNK_W;

  typedef enum logic {
    WCB_IDLE,
    WCB_SEND
  } wcb_state_t;
endpackage

//--- rtl/wcb_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module wcb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1) begin
      $error("wcb_fifo: DEPTH must be a power of two of at least 2");
    end
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] rd;
    logic [PW-1:0] wr;
    logic [PW:0] cnt;
    logic ov;
    logic [WIDTH-1:0] od;
  } wcb_fifo_regs_t;

  wcb_fifo_regs_t q, d;
  logic push, pop;

  assign in_ready = (q.cnt < (PW+1)'(DEPTH));
  assign out_valid = q.ov;
  assign out_data = q.od;

  always_comb begin
    d = q;
    push = in_valid && in_ready;
    pop = (q.cnt != '0) && (!q.ov || out_ready);
    if (q.ov && out_ready) begin
      d.ov = 1'b0;
    end
    // Output stage refills from the head entry
    if (pop) begin
      d.od = q.mem[q.rd];
      d.ov = 1'b1;
      d.rd = q.rd + 1'b1;
    end
    if (push) begin
      d.mem[q.wr] = in_data;
      d.wr = q.wr + 1'b1;
    end
    d.cnt = q.cnt + (PW+1)'(push) - (PW+1)'(pop);
    if (!ce) begin
      d = q;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule
`default_nettype wire

//--- rtl/wcb_combining_line_store.sv
// What this block does
// R1 - Write-combine stores sit in dedicated line buffers, apart from caches.
// R2 - Buffers are never snooped; no coherency with memory or caches.
// R3 - Repeated writes to one byte keep only the newest value.
// R4 - Several independent line buffers, 64 or 32 bytes each, width a parameter.
// R5 - Buffers fill one at a time, one open buffer only; a store that hits a closed, not yet evicted buffer still merges into it.
// R6 - Filled buffers may be evicted whenever and in any order.
// R7 - Issuer must drain buffers explicitly when memory coherency matters.
// R8 - Partly filled buffer may wait until a serializing event forces it out.
// R9 - Fully valid buffer leaves as one burst of the whole line.
// R10 - Buffer with unwritten bytes leaves as 8-byte partial writes.
// R11 - Evicting data is weakly ordered against other weak traffic.
// R12 - No order kept between successive line buffers.
// R13 - Partial writes of one buffer carry no chunk order guarantee.
// R14 - Full buffer always goes as one burst transaction.
// R15 - All valid bytes of one aligned chunk travel in one transaction.
// R16 - Per-byte valid mask set by stores, cleared on eviction, steers eviction.
// R17 - Matching store merges; else allocate free buffer, evicting first if none.
`timescale 1ns/10ps
`default_nettype none
module wcb_combining_line_store #(
  parameter int LINE_BYTES = wcb_pkg::LINE_BYTES_WIDE,
  parameter int NUM_LINES = wcb_pkg::NUM_LINES_DEF,
  parameter int FIFO_DEPTH = wcb_pkg::FIFO_DEPTH_DEF
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic st_valid,
  output logic st_ready,
  input wire logic [wcb_pkg::ADDR_W-1:0] st_addr,
  input wire logic [wcb_pkg::CHUNK_W-1:0] st_data,
  input wire logic [wcb_pkg::CHUNK_BYTES-1:0] st_be,
  input wire logic drain_req,
  output logic drain_busy,
  output logic drain_done,
  output logic bus_valid,
  input wire logic bus_ready,
  output logic bus_burst,
  output logic bus_last,
  output logic [wcb_pkg::ADDR_W-1:0] bus_addr,
  output logic [wcb_pkg::CHUNK_BYTES-1:0] bus_mask,
  output logic [wcb_pkg::CHUNK_W-1:0] bus_data
);
  import wcb_pkg::*;

  localparam int LINE_OFF_W = $clog2(LINE_BYTES);
  localparam int TAG_W = ADDR_W - LINE_OFF_W;
  localparam int CHUNKS = LINE_BYTES / CHUNK_BYTES;
  localparam int CIDX_W = $clog2(CHUNKS);
  localparam int IDX_W = $clog2(NUM_LINES);
  localparam logic [CIDX_W-1:0] LAST_CHUNK = CIDX_W'(CHUNKS - 1);

  initial begin
    if (LINE_BYTES != LINE_BYTES_WIDE && LINE_BYTES != LINE_BYTES_NARROW) begin
      $error("wcb_combining_line_store: LINE_BYTES must be 32 or 64"); // [R4]
    end
    if (NUM_LINES < 2 || (1 << IDX_W) != NUM_LINES) begin
      $error("wcb_combining_line_store: NUM_LINES must be a power of two >= 2");
    end
  end

  typedef struct packed {
    logic [NUM_LINES-1:0] valid;
    logic [NUM_LINES-1:0] closed;
    logic [NUM_LINES-1:0][TAG_W-1:0] tag;
    logic [NUM_LINES-1:0][LINE_BYTES-1:0] mask;
    logic [NUM_LINES-1:0][LINE_BYTES*8-1:0] data;
    logic open_vld;
    logic [IDX_W-1:0] open_idx;
    wcb_state_t st;
    logic [IDX_W-1:0] vic;
    logic [CIDX_W-1:0] chunk;
    logic drain;
    logic drain_done;
    logic st_ready;
  } wcb_regs_t;

  wcb_regs_t q, d;

  logic push;
  logic push_ready;
  logic [BUS_W-1:0] push_word;
  logic [BUS_W-1:0] pop_word;

  // Lowest set bit of a buffer vector
  function automatic logic [IDX_W-1:0] first_set(input logic [NUM_LINES-1:0] v);
    logic [IDX_W-1:0] r;
    r = '0;
    for (int i = NUM_LINES - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = IDX_W'(i);
      end
    end
    return r;
  endfunction

  logic [TAG_W-1:0] st_tag;
  logic [CIDX_W-1:0] st_chunk;
  logic st_take;
  logic st_hit;
  logic [IDX_W-1:0] st_idx;
  logic [NUM_LINES-1:0] cand;
  logic [NUM_LINES-1:0] hit_vec;
  logic vic_full;
  logic [CHUNK_BYTES-1:0] vic_cmask;
  logic vic_need;

  assign st_tag = st_addr[ADDR_W-1:LINE_OFF_W];
  assign st_chunk = st_addr[LINE_OFF_W-1:CHUNK_OFF_W];
  assign st_take = q.st_ready && st_valid;

  // Per-line tag match against locally held lines; no outside snoop port
  generate
    for (genvar g = 0; g < NUM_LINES; g++) begin : g_match
      assign hit_vec[g] = q.valid[g] && (q.tag[g] == st_tag); // [R2]
    end
  endgenerate

  always_comb begin
    d = q;
    d.drain_done = 1'b0;
    push = 1'b0;
    push_word = '0;
    st_hit = |hit_vec;
    st_idx = st_hit ? first_set(hit_vec) : first_set(~q.valid); // [R17]
    cand = q.valid & q.closed;
    vic_full = &q.mask[q.vic];
    vic_cmask = q.mask[q.vic][q.chunk*CHUNK_BYTES +: CHUNK_BYTES];
    vic_need = vic_full || (vic_cmask != BE_NONE);

    if (st_take) begin
      if (!st_hit) begin
        // Only one line open at a time; the old one becomes evictable
        if (q.open_vld) begin
          d.closed[q.open_idx] = 1'b1; // [R5]
        end
        d.valid[st_idx] = 1'b1; // [R17]
        d.closed[st_idx] = 1'b0;
        d.tag[st_idx] = st_tag;
        d.mask[st_idx] = '0;
        d.open_idx = st_idx; // [R5]
        d.open_vld = 1'b1;
      end
      // Byte merge: newest value overwrites, mask marks byte valid
      for (int b = 0; b < CHUNK_BYTES; b++) begin
        if (st_be[b]) begin
          d.data[st_idx][(st_chunk*CHUNK_BYTES+b)*8 +: 8] = st_data[b*8 +: 8]; // [R3] [R1]
          d.mask[st_idx][st_chunk*CHUNK_BYTES+b] = 1'b1; // [R16]
        end
      end
    end

    case (q.st)
      WCB_IDLE: begin
        if (!st_take) begin
          // Serializing event pushes the open line out too
          if (q.drain && q.open_vld) begin
            d.closed[q.open_idx] = 1'b1; // [R8]
            d.open_vld = 1'b0;
          end
          // Any closed line may go, lowest index first, no age order
          if (cand != '0) begin
            d.vic = first_set(cand); // [R6] [R12]
            d.st = WCB_SEND;
            d.chunk = '0;
          end else if (q.drain && q.valid == '0) begin
            d.drain = 1'b0;
            d.drain_done = 1'b1;
          end
        end
      end
      WCB_SEND: begin
        if (!vic_need || push_ready) begin
          if (vic_need) begin
            push = 1'b1; // [R11]
            // Full line: one burst of all chunks; else one partial per chunk that holds valid bytes
            push_word = {vic_full, // [R9] [R14] [R10]
                         (!vic_full || q.chunk == LAST_CHUNK),
                         q.tag[q.vic], q.chunk, CHUNK_OFF_ZERO,
                         vic_full ? {CHUNK_BYTES{1'b1}} : vic_cmask, // [R15]
                         q.data[q.vic][q.chunk*CHUNK_W +: CHUNK_W]}; // [R13]
          end
          if (q.chunk == LAST_CHUNK) begin
            d.valid[q.vic] = 1'b0;
            d.closed[q.vic] = 1'b0;
            d.mask[q.vic] = '0; // [R16]
            d.st = WCB_IDLE;
          end else begin
            d.chunk = q.chunk + 1'b1;
          end
        end
      end
      default: begin
        d.st = WCB_IDLE;
      end
    endcase

    // Request arriving with the clear still wins
    if (drain_req) begin
      d.drain = 1'b1; // [R8]
    end
    // Take a store only when a free line is sure to exist
    d.st_ready = (d.st == WCB_IDLE) && !d.drain && (d.valid != '1); // [R17]

    if (!ce) begin
      d = q;
      push = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  wcb_fifo #(
    .WIDTH(BUS_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .in_valid(push),
    .in_ready(push_ready),
    .in_data(push_word),
    .out_valid(bus_valid),
    .out_ready(bus_ready),
    .out_data(pop_word)
  );

  assign bus_burst = pop_word[BUS_W-1];
  assign bus_last = pop_word[BUS_W-2];
  assign bus_addr = pop_word[BUS_W-3 -: ADDR_W];
  assign bus_mask = pop_word[CHUNK_W +: CHUNK_BYTES];
  assign bus_data = pop_word[CHUNK_W-1:0];
  assign st_ready = q.st_ready;
  assign drain_busy = q.drain;
  assign drain_done = q.drain_done;
endmodule
`default_nettype wire

//--- testbench/wcb_props.sv
`timescale 1ns/10ps
`default_nettype none
module wcb_props (
  input wire logic clk,
  input wire logic reset,
  input wire logic drain_req,
  input wire logic drain_busy,
  input wire logic drain_done,
  input wire logic st_ready,
  input wire logic bus_valid,
  input wire logic bus_ready,
  input wire logic bus_burst,
  input wire logic bus_last,
  input wire logic [31:0] bus_addr,
  input wire logic [7:0] bus_mask,
  input wire logic [63:0] bus_data
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_mid;
    bus_valid && bus_ready && bus_burst && !bus_last;
  endsequence
  sequence s_next;
    ##[1:8] (bus_valid && bus_burst);
  endsequence
  a_word_held: assert property (bus_valid && !bus_ready |=>
    bus_valid && $stable({bus_addr, bus_mask, bus_data, bus_last, bus_burst}))
    else $error("bus word changed while stalled");
  a_chunk_aligned: assert property (bus_valid |-> bus_addr[2:0] == 3'h0)
    else $error("bus address not chunk aligned");
  a_burst_mask: assert property (bus_valid && bus_burst |-> bus_mask == 8'hff)
    else $error("burst word with partial mask");
  a_partial_single: assert property (bus_valid && !bus_burst |-> bus_last && bus_mask != 0)
    else $error("bad partial word");
  a_burst_whole: assert property (s_mid |-> s_next)
    else $error("burst broken off");
  a_drain_blocks: assert property (drain_busy |-> !st_ready)
    else $error("store accepted during drain");
  a_drain_start: assert property (drain_req && !drain_busy |=> drain_busy || drain_done)
    else $error("drain not started");
  a_done_pulse: assert property (drain_done |=> !drain_done)
    else $error("drain done longer than one cycle");
endmodule
bind wcb_combining_line_store wcb_props u_props (.clk, .reset, .drain_req, .drain_busy,
  .drain_done, .st_ready, .bus_valid, .bus_ready, .bus_burst, .bus_last, .bus_addr,
  .bus_mask, .bus_data);
`default_nettype wire

//--- testbench/wcb_bus_sink.sv
`timescale 1ns/10ps
`default_nettype none
module wcb_bus_sink (
  input wire logic clk,
  input wire logic reset,
  input wire logic stall,
  output logic bus_ready
);
  logic [7:0] lfsr_q;
  // Random back-pressure while stall is set
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      lfsr_q <= 8'h5a;
    end else begin
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
    end
  end
  assign bus_ready = !stall || lfsr_q[0];
endmodule
`default_nettype wire

//--- testbench/write_combining_buffer_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module write_combining_buffer_tb_top;
  import wcb_pkg::*;
  logic clk = 0, reset = 1, st_valid = 0, drain_req = 0, stall = 0;
  logic [31:0] st_addr = 32'h0000_0000, seed = 32'h0000_0037;
  logic [63:0] st_data = 64'h0000_0000_0000_0000;
  logic [7:0] st_be = 8'h00;
  logic st_ready, drain_busy, drain_done, bus_valid, bus_ready, bus_burst, bus_last;
  logic [31:0] bus_addr;
  logic [7:0] bus_mask;
  logic [63:0] bus_data;
  logic [7:0] got_mem [logic [31:0]];
  logic [7:0] want_mem [logic [31:0]];
  int mismatches = 0, n_compared = 0, nb = 0, np = 0;
  always #12.5 clk = ~clk;
  wcb_combining_line_store #(.LINE_BYTES(32)) dut (.clk, .reset, .ce(1'b1), .st_valid,
    .st_ready, .st_addr, .st_data, .st_be, .drain_req, .drain_busy, .drain_done,
    .bus_valid, .bus_ready, .bus_burst, .bus_last, .bus_addr, .bus_mask, .bus_data);
  wcb_bus_sink partner (.clk, .reset, .stall, .bus_ready);
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [7:0] lane(logic [63:0] d, int b);
    return d[8*b+:8];
  endfunction
  task automatic cmp(logic [63:0] got, logic [63:0] want, string what);
    n_compared++;
    if (got !== want) begin
      mismatches++;
      $display("FAIL %0t %s got %h want %h", $time, what, got, want);
    end
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Memory side: apply every accepted bus word
  always @(posedge clk) begin
    if (bus_valid && bus_ready) begin
      for (int b = 0; b < 8; b++) begin
        if (bus_mask[b]) got_mem[bus_addr + b] = lane(bus_data, b);
      end
      if (bus_burst) begin
        nb++;
        cmp(bus_last, nb % 4 == 0, "burst last");
      end else begin
        np++;
      end
    end
  end
  task automatic store(logic [31:0] a, logic [63:0] d, logic [7:0] be);
    st_valid <= 1'b1;
    st_addr <= a;
    st_data <= d;
    st_be <= be;
    for (int b = 0; b < 8; b++) begin
      if (be[b]) want_mem[{a[31:3], 3'h0} + b] = lane(d, b);
    end
    @(negedge clk);
    while (st_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
  endtask
  task automatic drain();
    st_valid <= 1'b0;
    drain_req <= 1'b1;
    @(posedge clk);
    drain_req <= 1'b0;
    @(negedge clk);
    while (drain_done !== 1'b1) @(negedge clk);
    repeat (3) @(negedge clk);
    while (bus_valid !== 1'b0) @(negedge clk);
    @(posedge clk);
  endtask
  task automatic check_mem();
    foreach (want_mem[a]) cmp(got_mem.exists(a) ? got_mem[a] : 8'hxx, want_mem[a], "byte");
    foreach (got_mem[a]) cmp(want_mem.exists(a), 1, "extra byte");
  endtask
  initial begin
    #500000;
    mismatches++;
    $display("FAIL %0t watchdog expired", $time);
    test_done();
  end
  initial begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    // Full line with an overwritten chunk, closed by a miss
    store(32'h0000_0100, 64'h1111_1111_1111_1111, 8'hff);
    for (int c = 0; c < 4; c++) store(32'h0000_0100 + 8 * c, {rnd(), rnd()}, 8'hff);
    store(32'h0000_0208, 64'h0123_4567_89ab_cdef, 8'h0f);
    drain();
    cmp(nb, 4, "burst words");
    cmp(np, 1, "partial words");
    check_mem();
    // Random stores over eight lines with bus stalls
    stall <= 1'b1;
    for (int i = 0; i < 40; i++) store(32'h0000_1000 + (rnd() & 32'h0000_00f8),
      {rnd(), rnd()}, 8'(rnd()));
    drain();
    check_mem();
    cmp(nb % 4, 0, "burst count");
    test_done();
  end
endmodule
`default_nettype wire
